/* design/cfrc_top.sv */
`timescale 1ns/100ps
// Undercurrent response and average overcurrent threshold, per page.
module cfrc_top #(
    parameter int TICK_CYC = cfrc_pkg::CFRC_TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Command port from the bus engine
    input wire cfrc_pkg::cfrc_cmd_t cmd,
    output logic [15:0] rdata,
    // Strap-selected default threshold, one value loaded into both pages
    input wire logic [15:0] strap_limit,
    // Sensing, per page; up_slope is shared by both pages
    input wire logic [1:0] uc_fault,
    input wire logic [1:0] off_cmd,
    input wire logic [1:0] bias_ok,
    input wire logic [1:0] other_fault,
    input wire logic up_slope,
    input wire cfrc_pkg::cfrc_sample_t smp0,
    input wire cfrc_pkg::cfrc_sample_t smp1,
    // Outputs
    output logic [1:0] out_enable,
    output logic [1:0] uc_flag,
    output logic [1:0] oc_flag,
    output logic [1:0] avg_oc_event,
    output logic shared_alert_line_n
);
    typedef enum logic [2:0] {
        CFRC_RUN = 3'h1,
        CFRC_OFF = 3'h2,
        CFRC_WAIT = 3'h4
    } cfrc_state_t;

    logic [7:0] undercurrent_fault_response [cfrc_pkg::CFRC_PAGES];
    logic [15:0] average_overcurrent_threshold [cfrc_pkg::CFRC_PAGES];
    logic strap_done;
    logic [1:0] uc_s1, uc_s2, off_s1, off_s2, bias_s1, bias_s2;
    logic [1:0] oth_s1, oth_s2;
    cfrc_state_t st [cfrc_pkg::CFRC_PAGES];
    logic [31:0] pre;
    logic tick;
    logic [2:0] dly [cfrc_pkg::CFRC_PAGES];
    logic [1:0] av_valid;
    logic signed [15:0] av [cfrc_pkg::CFRC_PAGES];
    logic [1:0] oc_hit;

    // Linear value scaled to samples' fixed point; no saturation, so a large
    // exponent can overflow the 32 bits; samples span at most 128 A
    function automatic logic signed [31:0] lin_fix(input logic [15:0] w);
        logic signed [4:0] n;
        logic signed [31:0] y;
        logic signed [7:0] sh;
        n = w[cfrc_pkg::CFRC_EXP_HI:cfrc_pkg::CFRC_EXP_LO];
        y = {{21{w[cfrc_pkg::CFRC_MAN_HI]}}, w[cfrc_pkg::CFRC_MAN_HI:0]};
        sh = 8'(n) + 8'(cfrc_pkg::CFRC_FRAC);
        if (sh >= 0)
            lin_fix = y <<< sh;
        else
            lin_fix = y >>> (-sh);
    endfunction : lin_fix

    // Synchronisers for pin-level inputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            uc_s1 <= 2'h0;
            uc_s2 <= 2'h0;
            off_s1 <= 2'h0;
            off_s2 <= 2'h0;
            bias_s1 <= 2'h0;
            bias_s2 <= 2'h0;
            oth_s1 <= 2'h0;
            oth_s2 <= 2'h0;
        end else begin
            uc_s1 <= uc_fault;
            uc_s2 <= uc_s1;
            off_s1 <= off_cmd;
            off_s2 <= off_s1;
            bias_s1 <= bias_ok;
            bias_s2 <= bias_s1;
            oth_s1 <= other_fault;
            oth_s2 <= oth_s1;
        end
    end

    // Register writes; strap captured once after reset release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int p = 0; p < cfrc_pkg::CFRC_PAGES; p++) begin
                undercurrent_fault_response[p] <= cfrc_pkg::CFRC_UC_RESP_RST;
                average_overcurrent_threshold[p] <= 16'h0;
            end
            strap_done <= 1'b0;
        end else begin
            if (!strap_done) begin
                for (int p = 0; p < cfrc_pkg::CFRC_PAGES; p++)
                    average_overcurrent_threshold[p] <= strap_limit;
                strap_done <= 1'b1;
            end else if (cmd.wr && !cmd.protect) begin
                if (cmd.cmd == cfrc_pkg::CFRC_UC_RESP_CMD)
                    undercurrent_fault_response[cmd.page] <= cmd.wdata[7:0];
                else if (cmd.cmd == cfrc_pkg::CFRC_AVG_OC_CMD)
                    average_overcurrent_threshold[cmd.page] <= cmd.wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 16'h0;
        end else if (cmd.rd) begin
            if (cmd.cmd == cfrc_pkg::CFRC_UC_RESP_CMD)
                rdata <= {8'h00, undercurrent_fault_response[cmd.page]};
            else if (cmd.cmd == cfrc_pkg::CFRC_AVG_OC_CMD)
                rdata <= average_overcurrent_threshold[cmd.page];
            else
                rdata <= 16'h0;
        end
    end

    // 35 ms prescaler, free running; shared by both pages, no page restarts it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick <= (pre == 32'(TICK_CYC - 1));
            pre <= (pre == 32'(TICK_CYC - 1)) ? 32'h0 : pre + 32'h1;
        end
    end

    cfrc_avg u_avg0 (
        .clk(clk),
        .sys_rst(sys_rst),
        .smp(smp0),
        .up_slope(up_slope),
        .avg_valid(av_valid[0]),
        .avg(av[0])
    );
    cfrc_avg u_avg1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .smp(smp1),
        .up_slope(up_slope),
        .avg_valid(av_valid[1]),
        .avg(av[1])
    );

    always_comb begin
        for (int p = 0; p < cfrc_pkg::CFRC_PAGES; p++)
            oc_hit[p] = av_valid[p] && strap_done &&
                ($signed({{16{av[p][15]}}, av[p]}) >
                 lin_fix(average_overcurrent_threshold[p]));
    end

    // Sticky flags: set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            uc_flag <= 2'h0;
            oc_flag <= 2'h0;
            avg_oc_event <= 2'h0;
            shared_alert_line_n <= 1'b1;
        end else begin
            avg_oc_event <= oc_hit;
            for (int p = 0; p < cfrc_pkg::CFRC_PAGES; p++) begin
                if (uc_s2[p])
                    uc_flag[p] <= 1'b1;
                else if (cmd.clear_faults)
                    uc_flag[p] <= 1'b0;
                if (oc_hit[p])
                    oc_flag[p] <= 1'b1;
                else if (cmd.clear_faults)
                    oc_flag[p] <= 1'b0;
            end
            shared_alert_line_n <= !(|uc_s2 || |oc_hit ||
                ((|uc_flag || |oc_flag) && !cmd.clear_faults));
        end
    end

    // Per-page response machine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int p = 0; p < cfrc_pkg::CFRC_PAGES; p++) begin
                st[p] <= CFRC_RUN;
                dly[p] <= 3'h0;
            end
            out_enable <= 2'h0;
        end else begin
            for (int p = 0; p < cfrc_pkg::CFRC_PAGES; p++) begin
                logic [1:0] md;
                logic [2:0] rt;
                md = undercurrent_fault_response[p][cfrc_pkg::CFRC_MODE_HI:
                                                     cfrc_pkg::CFRC_MODE_LO];
                rt = undercurrent_fault_response[p][cfrc_pkg::CFRC_RTRY_HI:
                                                     cfrc_pkg::CFRC_RTRY_LO];
                case (st[p])
                    CFRC_RUN: begin
                        out_enable[p] <= 1'b1;
                        if (uc_s2[p]) begin
                            out_enable[p] <= 1'b0;
                            if (md == cfrc_pkg::CFRC_MODE_HOLD) begin
                                st[p] <= CFRC_OFF;
                            end else if (md == cfrc_pkg::CFRC_MODE_RETRY &&
                                    rt == cfrc_pkg::CFRC_RETRY_CONT) begin
                                st[p] <= CFRC_WAIT;
                                dly[p] <= 3'h0;
                            end else begin
                                st[p] <= CFRC_OFF;
                            end
                        end
                    end
                    CFRC_OFF: begin
                        out_enable[p] <= 1'b0;
                        if (md == cfrc_pkg::CFRC_MODE_HOLD) begin
                            if (!uc_s2[p])
                                st[p] <= CFRC_RUN;
                        end else if (cmd.clear_faults) begin
                            st[p] <= CFRC_RUN;
                        end
                    end
                    CFRC_WAIT: begin
                        out_enable[p] <= 1'b0;
                        if (off_s2[p] || !bias_s2[p] || oth_s2[p]) begin
                            st[p] <= CFRC_OFF;
                        end else if (tick) begin
                            if (dly[p] == undercurrent_fault_response[p]
                                    [cfrc_pkg::CFRC_DLY_HI:0]) begin
                                st[p] <= CFRC_RUN;
                                out_enable[p] <= 1'b1;
                            end else begin
                                dly[p] <= dly[p] + 3'h1;
                            end
                        end
                    end
                    default: st[p] <= CFRC_RUN;
                endcase
            end
        end
    end

    property p_uc_sets_flag;
        @(posedge clk) disable iff (sys_rst)
        uc_s2[0] |=> uc_flag[0] && !shared_alert_line_n;
    endproperty
    a_uc_sets_flag: assert property (p_uc_sets_flag)
        else $error("undercurrent did not set flag and alert");

    property p_flag_sticky;
        @(posedge clk) disable iff (sys_rst)
        (uc_flag[0] && !cmd.clear_faults) |=> uc_flag[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without clear");

    property p_shutdown_now;
        @(posedge clk) disable iff (sys_rst)
        (st[0] == CFRC_RUN && uc_s2[0]) |=> !out_enable[0];
    endproperty
    a_shutdown_now: assert property (p_shutdown_now)
        else $error("output not disabled on fault");

    property p_no_retry;
        @(posedge clk) disable iff (sys_rst)
        (st[0] == CFRC_OFF && !cmd.clear_faults &&
         undercurrent_fault_response[0][cfrc_pkg::CFRC_MODE_HI:
             cfrc_pkg::CFRC_MODE_LO] != cfrc_pkg::CFRC_MODE_HOLD)
        |=> st[0] == CFRC_OFF;
    endproperty
    a_no_retry: assert property (p_no_retry)
        else $error("left off state without clear");

    property p_hold_resume;
        @(posedge clk) disable iff (sys_rst)
        (st[0] == CFRC_OFF && !uc_s2[0] &&
         undercurrent_fault_response[0][cfrc_pkg::CFRC_MODE_HI:
             cfrc_pkg::CFRC_MODE_LO] == cfrc_pkg::CFRC_MODE_HOLD)
        |=> st[0] == CFRC_RUN;
    endproperty
    a_hold_resume: assert property (p_hold_resume)
        else $error("output not resumed after fault gone");

    property p_retry_stop;
        @(posedge clk) disable iff (sys_rst)
        (st[0] == CFRC_WAIT && off_s2[0]) |=> st[0] == CFRC_OFF;
    endproperty
    a_retry_stop: assert property (p_retry_stop)
        else $error("retry not stopped by off command");

    property p_oc_flag;
        @(posedge clk) disable iff (sys_rst)
        oc_hit[0] |=> oc_flag[0] && avg_oc_event[0];
    endproperty
    a_oc_flag: assert property (p_oc_flag)
        else $error("average overcurrent flag missing");

    property p_reset_value;
        @(posedge clk)
        sys_rst |=>
            undercurrent_fault_response[0] == cfrc_pkg::CFRC_UC_RESP_RST;
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("response register reset value wrong");

    // Threshold must follow the strap on the first edge after reset
    property p_strap_load;
        @(posedge clk) disable iff (sys_rst)
        !strap_done |=>
            average_overcurrent_threshold[0] == $past(strap_limit);
    endproperty
    a_strap_load: assert property (p_strap_load)
        else $error("strap threshold not loaded");
endmodule : cfrc_top

/* design/cfrc_pkg.sv */
// Operation
// - Mode 10 shuts the output off at once, then follows the retry setting; the code restarts only for setting 111, every other setting latches off.
// - Mode 11 holds the output off only while the fault persists.
// - Any undercurrent fault drives the alert line low and sets its flag.
// - Fault flags stay set until the clear-faults command.
// - Undercurrent response sets the undercurrent bit of the current status; the code has no status register, only uc_flag.
// - Retry setting 000 makes no restart; output stays off until cleared.
// - Retry 111 restarts repeatedly until off command, bias loss, other fault.
// - Restart interval is (delay field plus one) times 35 ms.
// - Undercurrent response register resets to 80h.
// - Undercurrent response is a paged, protectable read/write byte.
// - Average overcurrent threshold is a paged, protectable two-byte value.
// - Down-slope average covers switch-off samples after blanking.
// - Up-slope average covers switch-on samples after blanking.
// - Average overcurrent sets the overcurrent flag and its fault response; the code sets oc_flag and pulses avg_oc_event but never drops out_enable.
// - Threshold means signed mantissa times two to a signed exponent.
// - Threshold loads from the strap-selected value at power-up.
package cfrc_pkg;
    localparam logic [7:0] CFRC_UC_RESP_CMD = 8'hE6;
    localparam logic [7:0] CFRC_AVG_OC_CMD = 8'hE7;
    localparam logic [7:0] CFRC_UC_RESP_RST = 8'h80;
    localparam int CFRC_PAGES = 2;
    localparam int CFRC_CLK_MHZ = 125;
    localparam int CFRC_TICK_MS = 35;
    localparam int CFRC_TICK_CYC = CFRC_TICK_MS * 1000 * CFRC_CLK_MHZ;
    localparam logic [1:0] CFRC_MODE_RETRY = 2'h2;
    localparam logic [1:0] CFRC_MODE_HOLD = 2'h3;
    localparam logic [2:0] CFRC_RETRY_NONE = 3'h0;
    localparam logic [2:0] CFRC_RETRY_CONT = 3'h7;
    localparam int CFRC_MODE_HI = 7;
    localparam int CFRC_MODE_LO = 6;
    localparam int CFRC_RTRY_HI = 5;
    localparam int CFRC_RTRY_LO = 3;
    localparam int CFRC_DLY_HI = 2;
    localparam int CFRC_EXP_HI = 15;
    localparam int CFRC_EXP_LO = 11;
    localparam int CFRC_MAN_HI = 10;
    // Current samples are signed amperes with this many fraction bits
    localparam int CFRC_FRAC = 8;
    localparam int CFRC_ACC_W = 32;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic page;
        logic [15:0] wdata;
        logic protect;
        logic clear_faults;
    } cfrc_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] amps;
        logic on_phase;
        logic blank;
    } cfrc_sample_t;
endpackage : cfrc_pkg

/* design/cfrc_avg.sv */
`timescale 1ns/100ps
// Averages current samples over the sensed interval, skipping blanking.
module cfrc_avg (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Sample stream
    input wire cfrc_pkg::cfrc_sample_t smp,
    input wire logic up_slope,
    // Result
    output logic avg_valid,
    output logic signed [15:0] avg
);
    logic signed [cfrc_pkg::CFRC_ACC_W-1:0] acc;
    logic [15:0] cnt;
    logic in_win;
    logic was_in;

    always_comb begin
        // Up-slope uses the on time, down-slope the off time
        in_win = smp.valid && (smp.on_phase == up_slope) && !smp.blank;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc <= '0;
            cnt <= 16'h0;
            was_in <= 1'b0;
            avg_valid <= 1'b0;
            avg <= 16'sh0;
        end else begin
            avg_valid <= 1'b0;
            if (in_win) begin
                acc <= acc + {{(cfrc_pkg::CFRC_ACC_W-16){smp.amps[15]}},
                              smp.amps};
                cnt <= cnt + 16'h1;
                was_in <= 1'b1;
            end else if (smp.valid && was_in && !smp.blank) begin
                // Interval ended: mean of samples; divider kept simple
                avg <= 16'(acc / $signed({16'h0, cnt}));
                avg_valid <= 1'b1;
                acc <= '0;
                cnt <= 16'h0;
                was_in <= 1'b0;
            end
        end
    end

    property p_avg_after_window;
        @(posedge clk) disable iff (sys_rst)
        (smp.valid && was_in && !in_win && !smp.blank) |=> avg_valid;
    endproperty
    a_avg_after_window: assert property (p_avg_after_window)
        else $error("average not produced at interval end");
endmodule : cfrc_avg

/* verif/cfrc_host.sv */
`timescale 1ns/100ps
// Host side of the command port, as the bus engine presents it
module cfrc_host (
    // Clock
    input wire logic clk,
    // Command port
    output cfrc_pkg::cfrc_cmd_t cmd,
    input wire logic [15:0] rdata
);
    initial begin
        cmd = '0;
    end

    // Page goes out with every access so nothing lands on a stale page
    task automatic xfer(input logic pg, input logic wr, input logic [7:0] code,
        input logic [15:0] wd, input logic prot, output logic [15:0] rd);
        @(posedge clk);
        cmd.page <= pg;
        cmd.cmd <= code;
        cmd.wdata <= wd;
        cmd.protect <= prot;
        cmd.wr <= wr;
        cmd.rd <= !wr;
        @(posedge clk);
        cmd.wr <= 1'b0;
        cmd.rd <= 1'b0;
        #1;
        rd = rdata;
    endtask : xfer

    task automatic clear();
        @(posedge clk);
        cmd.clear_faults <= 1'b1;
        @(posedge clk);
        cmd.clear_faults <= 1'b0;
    endtask : clear
endmodule : cfrc_host

/* verif/cfrc_top_tb.sv */
`timescale 1ns/100ps
module cfrc_top_tb;
    localparam int TICK = 10;
    // Arbitrary strap threshold
    localparam logic [15:0] STRAP = 16'hD3C0;
    localparam logic [7:0] UC = 8'hE6;
    localparam logic [7:0] OC = 8'hE7;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] strap_limit = STRAP;
    logic [1:0] uc_fault = 2'h0;
    logic [1:0] off_cmd = 2'h0;
    logic [1:0] bias_ok = 2'h3;
    logic [1:0] other_fault = 2'h0;
    logic up_slope = 1'b0;
    cfrc_pkg::cfrc_sample_t smp0 = '0;
    cfrc_pkg::cfrc_sample_t smp1 = '0;
    cfrc_pkg::cfrc_cmd_t cmd;
    logic [15:0] rdata;
    logic [1:0] out_enable;
    logic [1:0] uc_flag;
    logic [1:0] oc_flag;
    logic [1:0] avg_oc_event;
    logic alert_n;
    logic [15:0] d;
    int num_errors = 0;
    int samples_checked = 0;
    int oc_events = 0;

    always #4 clk = ~clk;
    always @(posedge clk) if (avg_oc_event[0] === 1'b1) oc_events++;

    cfrc_top #(.TICK_CYC(TICK)) cfrc_top_i (.clk(clk), .sys_rst(sys_rst),
        .cmd(cmd), .rdata(rdata), .strap_limit(strap_limit),
        .uc_fault(uc_fault), .off_cmd(off_cmd), .bias_ok(bias_ok),
        .other_fault(other_fault), .up_slope(up_slope), .smp0(smp0),
        .smp1(smp1), .out_enable(out_enable), .uc_flag(uc_flag),
        .oc_flag(oc_flag), .avg_oc_event(avg_oc_event),
        .shared_alert_line_n(alert_n));
    cfrc_host cfrc_host_i (.clk(clk), .cmd(cmd), .rdata(rdata));

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s is %b", $time, what, got);
        end
    endtask : chk1

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic rd(input logic pg, input logic [7:0] code);
        cfrc_host_i.xfer(pg, 1'b0, code, 16'h0000, 1'b0, d);
    endtask : rd

    task automatic wr(input logic pg, input logic [7:0] code,
        input logic [15:0] v, input logic prot);
        cfrc_host_i.xfer(pg, 1'b1, code, v, prot, d);
    endtask : wr

    task automatic fault(input logic v);
        @(posedge clk);
        uc_fault[0] <= v;
    endtask : fault

    task automatic t_reset();
        for (int p = 0; p < 2; p++) begin
            rd(p[0], UC);
            chk16(d, 16'h0080);
            rd(p[0], OC);
            chk16(d, STRAP);
        end
        rd(1'b0, 8'hE5);
        chk16(d, 16'h0000);
        chk1(alert_n, 1'b1, "alert");
        chk1(out_enable[0], 1'b1, "enable");
    endtask : t_reset

    task automatic t_regs();
        wr(1'b0, UC, 16'hABF9, 1'b0);
        wr(1'b1, UC, 16'h0088, 1'b0);
        wr(1'b0, UC, 16'h0055, 1'b1);
        wr(1'b0, OC, 16'hF803, 1'b0);
        wr(1'b1, OC, 16'h07FF, 1'b0);
        wr(1'b1, OC, 16'h1234, 1'b1);
        rd(1'b0, UC);
        chk16(d, 16'h00F9);
        rd(1'b1, UC);
        chk16(d, 16'h0088);
        rd(1'b0, OC);
        chk16(d, 16'hF803);
        rd(1'b1, OC);
        chk16(d, 16'h07FF);
    endtask : t_regs

    // Shutdown codes that must latch off and never restart
    task automatic t_latch();
        logic [7:0] codes[4] = '{8'h80, 8'h00, 8'h48, 8'h88};
        foreach (codes[i]) begin
            wr(1'b0, UC, {8'h00, codes[i]}, 1'b0);
            fault(1'b1);
            cyc(5);
            chk1(out_enable[0], 1'b0, "enable");
            chk1(uc_flag[0], 1'b1, "uc flag");
            chk1(alert_n, 1'b0, "alert");
            chk1(oc_flag[0], 1'b0, "oc flag");
            chk1(uc_flag[1], 1'b0, "uc flag 1");
            chk1(out_enable[1], 1'b1, "enable 1");
            fault(1'b0);
            cyc(8 * TICK);
            chk1(out_enable[0], 1'b0, "enable");
            chk1(uc_flag[0], 1'b1, "uc flag");
            cfrc_host_i.clear();
            cyc(3);
            chk1(uc_flag[0], 1'b0, "uc flag");
            chk1(alert_n, 1'b1, "alert");
        end
    endtask : t_latch

    task automatic t_hold();
        wr(1'b0, UC, 16'h00C0, 1'b0);
        cyc(10);
        fault(1'b1);
        cyc(5);
        chk1(out_enable[0], 1'b0, "enable");
        fault(1'b0);
        cyc(5);
        chk1(out_enable[0], 1'b1, "enable");
        chk1(uc_flag[0], 1'b1, "uc flag");
        cfrc_host_i.clear();
    endtask : t_hold

    // Each pass stops the retries by another cause: off, bias loss, fault
    task automatic t_retry();
        int n;
        int up;
        wr(1'b0, UC, 16'h00B9, 1'b0);
        for (int k = 0; k < 3; k++) begin
            fault(1'b1);
            cyc(5);
            chk1(out_enable[0], 1'b0, "enable");
            n = 0;
            while (out_enable[0] !== 1'b1 && n < 60) begin
                cyc(1);
                n++;
            end
            // Free-running tick may shorten the first delay by up to a tick
            chk1(n >= TICK - 1 && n <= 2 * TICK, 1'b1, "retry gap");
            cyc(5);
            chk1(out_enable[0], 1'b0, "re-trip");
            @(posedge clk);
            off_cmd[0] <= (k == 0);
            bias_ok[0] <= (k != 1);
            other_fault[0] <= (k == 2);
            up = 0;
            for (int i = 0; i < 8 * TICK; i++) begin
                cyc(1);
                if (out_enable[0] !== 1'b0) up++;
            end
            chk1(up == 0, 1'b1, "stopped");
            @(posedge clk);
            off_cmd[0] <= 1'b0;
            bias_ok[0] <= 1'b1;
            other_fault[0] <= 1'b0;
            uc_fault[0] <= 1'b0;
            // Let the synchroniser drain so the clear is not beaten by a set
            cyc(4);
            cfrc_host_i.clear();
            cyc(3);
        end
    endtask : t_retry

    task automatic smp(input logic [15:0] a, input logic ph, input logic bl);
        @(posedge clk);
        smp0 <= '{valid: 1'b1, amps: a, on_phase: ph, blank: bl};
        @(posedge clk);
        smp0.valid <= 1'b0;
    endtask : smp

    // Blanked samples are far above the limit and must not count
    task automatic window(input logic sl, input logic [15:0] a);
        smp(16'h4000, sl, 1'b1);
        smp(a, sl, 1'b0);
        smp(a, sl, 1'b0);
        smp(16'h0000, !sl, 1'b0);
        cyc(5);
    endtask : window

    task automatic t_avg();
        int e;
        wr(1'b0, OC, 16'hF803, 1'b0);
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            up_slope <= s[0];
            e = oc_events;
            window(s[0], 16'h0140);
            chk1(oc_flag[0], 1'b0, "oc low");
            chk1(oc_events == e, 1'b1, "no event");
            window(s[0], 16'h01C0);
            chk1(oc_flag[0], 1'b1, "oc flag");
            chk1(oc_events == e + 1, 1'b1, "event");
            chk1(uc_flag[0], 1'b0, "uc flag");
            cfrc_host_i.clear();
            cyc(3);
        end
    endtask : t_avg

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(10);
        t_reset();
        t_regs();
        t_latch();
        t_hold();
        t_retry();
        t_avg();
        final_report();
    end

    initial begin
        #200000;
        num_errors++;
        final_report();
    end
endmodule : cfrc_top_tb
